// *** rtl/stk_pkg.sv ***
// constants for the system tick down counter: register map, field positions, reset values
// assumes a 32-bit word-wide register port with byte addresses
package stk_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] STK_ADDR_CONTROL_STATUS = 32'he000e010;
  localparam logic [31:0] STK_ADDR_RELOAD_VALUE = 32'he000e014;
  localparam logic [31:0] STK_ADDR_CURRENT_VALUE = 32'he000e018;
  localparam logic [31:0] STK_ADDR_CALIBRATION = 32'he000e01c;
  localparam logic [31:0] STK_ADDR_RANGE_FIRST = 32'he000e010;
  localparam logic [31:0] STK_ADDR_RANGE_LAST = 32'he000e0ff;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int STK_COUNT_WIDTH = 24;
  localparam int STK_BIT_ENABLE = 0;
  localparam int STK_BIT_EXC_ENABLE = 1;
  localparam int STK_BIT_CLOCK_SELECT = 2;
  localparam int STK_BIT_ZERO_FLAG = 16;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] STK_CSR_RESET_WITH_REF = 32'h00000000;
  localparam logic [31:0] STK_CSR_RESET_NO_REF = 32'h00000004;
  localparam logic [23:0] STK_RELOAD_RESET = 24'h000000;
  localparam logic [23:0] STK_CURRENT_RESET = 24'h000000;
  localparam logic [31:0] STK_READ_ZERO = 32'h00000000;

endpackage

// *** rtl/stk_ref_edge.sv ***
// synchroniser and rising-edge detector for the external reference clock
// assumes the reference clock is much slower than sys_clk (under half its rate)
`timescale 1ns/1ps
module stk_ref_edge (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // reference clock level, asynchronous
  input wire logic ref_level,
  // one-cycle pulse per rising edge
  output logic ref_rise
);

  logic sync_first;
  logic sync_second;
  logic sync_last;
  logic next_sync_first;
  logic next_sync_second;
  logic next_sync_last;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_sync_first = sync_first;
    next_sync_second = sync_second;
    next_sync_last = sync_last;
    if (clk_en) begin
      next_sync_first = ref_level;
      next_sync_second = sync_first;
      next_sync_last = sync_second;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_first <= 1'b0;
      sync_second <= 1'b0;
      sync_last <= 1'b0;
    end else begin
      sync_first <= next_sync_first;
      sync_second <= next_sync_second;
      sync_last <= next_sync_last;
    end
  end

  // only the second and third stages feed the edge detector
  assign ref_rise = sync_second & ~sync_last;

endmodule // stk_ref_edge

// *** rtl/stk_timer.sv ***
// system tick down counter with its four memory-mapped words
// assumes a simple word register port: one request per cycle, answered one cycle later
`timescale 1ns/1ps

// What this block does
// RULE1: reload register holds 24-bit value, loaded into counter when it reaches zero.
// RULE2: zero-reached flag at bit 16 sets when counter counts from 1 to 0.
// RULE3: zero-reached flag clears on status register read and current-value write.
// RULE4: status bit 2 picks count clock: 0 reference clock, 1 processor clock.
// RULE5: without a reference clock, clock select reads one and ignores writes.
// RULE6: exception enable bit 1 lets reaching zero pend the tick exception.
// RULE7: software clearing the counter never pends the tick exception.
// RULE8: status bit 0 enables counting; zero keeps the counter stopped.
// RULE9: upper 8 bits of reload and current value read zero, ignore writes.
// RULE10: any write to current value clears the counter to zero.
// RULE11: current value read returns the counter at the moment of access.
// RULE12: software must not expect atomic read-modify-write of the current value.
// RULE13: status register resets to zero, clock select to one when fixed.
// RULE14: with the timer absent the whole range reads zero and ignores writes.
// RULE15: enabled counter decrements each tick, reloads the tick after reaching zero.
// RULE16: after a current-value write the counter reloads on the next tick.
// RULE17: reload of zero leaves the counter parked at zero after the wrap.
// RULE18: while the processor is halted for debug the counter holds.
// RULE19: reference clock edges are synchronised into one-cycle count enables.
module stk_timer
  import stk_pkg::*;
#(
  parameter bit TIMER_PRESENT = 1'b1,
  parameter bit HAS_REF_CLOCK = 1'b1,
  parameter bit CALIB_SKEW = 1'b0,
  parameter logic [23:0] CALIB_TEN_MS = 24'h000000
) (
  // clock, reset, clock enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // register port
  input wire logic reg_sel,
  input wire logic reg_write,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  // processor status
  input wire logic debug_halted,
  // optional external reference clock
  input wire logic ref_clk_in,
  // tick exception pend request, one cycle
  output logic tick_pend
);

  localparam logic [31:0] CSR_RESET = HAS_REF_CLOCK ? STK_CSR_RESET_WITH_REF
                                                    : STK_CSR_RESET_NO_REF;

  logic count_enable;
  logic exc_enable;
  logic clock_select;
  logic zero_reached_flag;
  logic [STK_COUNT_WIDTH-1:0] reload_value;
  logic [STK_COUNT_WIDTH-1:0] current_value;
  logic [31:0] rdata_q;
  logic ack_q;
  logic pend_q;

  logic next_count_enable;
  logic next_exc_enable;
  logic next_clock_select;
  logic next_zero_reached_flag;
  logic [STK_COUNT_WIDTH-1:0] next_reload_value;
  logic [STK_COUNT_WIDTH-1:0] next_current_value;
  logic [31:0] next_rdata;
  logic next_ack;
  logic next_pend;

  logic ref_rise;
  logic in_range;
  logic wr_csr;
  logic wr_rvr;
  logic wr_cvr;
  logic rd_csr;
  logic count_tick;
  logic hit_zero;
  logic [31:0] read_word;

  // ----------------------------------------------------------------
  // reference clock crossing
  // ----------------------------------------------------------------
  stk_ref_edge u_ref_edge (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .ref_level(ref_clk_in),
    .ref_rise(ref_rise)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  always_comb begin
    in_range = TIMER_PRESENT && reg_sel && (reg_addr >= STK_ADDR_RANGE_FIRST)
               && (reg_addr <= STK_ADDR_RANGE_LAST); // [RULE14]
    wr_csr = in_range && reg_write && (reg_addr == STK_ADDR_CONTROL_STATUS);
    wr_rvr = in_range && reg_write && (reg_addr == STK_ADDR_RELOAD_VALUE);
    wr_cvr = in_range && reg_write && (reg_addr == STK_ADDR_CURRENT_VALUE);
    rd_csr = in_range && !reg_write && (reg_addr == STK_ADDR_CONTROL_STATUS);
  end

  // ----------------------------------------------------------------
  // count tick source
  // ----------------------------------------------------------------
  always_comb begin
    count_tick = 1'b0;
    if (count_enable && !debug_halted) begin // [RULE8] [RULE18]
      if (clock_select) begin
        count_tick = 1'b1; // [RULE4]
      end else begin
        count_tick = ref_rise; // [RULE4] [RULE19]
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    read_word = STK_READ_ZERO;
    if (in_range) begin
      case (reg_addr)
        STK_ADDR_CONTROL_STATUS: begin
          read_word[STK_BIT_ENABLE] = count_enable;
          read_word[STK_BIT_EXC_ENABLE] = exc_enable;
          read_word[STK_BIT_CLOCK_SELECT] = clock_select;
          read_word[STK_BIT_ZERO_FLAG] = zero_reached_flag;
        end
        STK_ADDR_RELOAD_VALUE: begin
          read_word[STK_COUNT_WIDTH-1:0] = reload_value; // [RULE9]
        end
        STK_ADDR_CURRENT_VALUE: begin
          read_word[STK_COUNT_WIDTH-1:0] = current_value; // [RULE9] [RULE11]
        end
        STK_ADDR_CALIBRATION: begin
          read_word[31] = ~HAS_REF_CLOCK;
          read_word[30] = CALIB_SKEW;
          read_word[STK_COUNT_WIDTH-1:0] = CALIB_TEN_MS;
        end
        default: begin
          read_word = STK_READ_ZERO;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_count_enable = count_enable;
    next_exc_enable = exc_enable;
    next_clock_select = clock_select;
    next_zero_reached_flag = zero_reached_flag;
    next_reload_value = reload_value;
    next_current_value = current_value;
    next_rdata = rdata_q;
    next_ack = reg_sel;
    next_pend = 1'b0;
    hit_zero = 1'b0;

    if (reg_sel && !reg_write) begin
      next_rdata = read_word;
    end

    if (wr_csr) begin
      next_count_enable = reg_wdata[STK_BIT_ENABLE];
      next_exc_enable = reg_wdata[STK_BIT_EXC_ENABLE];
      if (HAS_REF_CLOCK) begin
        next_clock_select = reg_wdata[STK_BIT_CLOCK_SELECT];
      end else begin
        next_clock_select = 1'b1; // [RULE5]
      end
    end
    if (wr_rvr) begin
      next_reload_value = reg_wdata[STK_COUNT_WIDTH-1:0]; // [RULE1] [RULE9]
    end

    // counting; a write to the current value overrides a tick in the same cycle
    if (count_tick) begin
      if (current_value == '0) begin
        next_current_value = reload_value; // [RULE1] [RULE15] [RULE16] [RULE17]
      end else begin
        next_current_value = current_value - 1'b1; // [RULE15]
        hit_zero = (current_value == 24'h000001);
      end
    end
    if (wr_cvr) begin
      next_current_value = '0; // [RULE10]
    end

    // flag clear, then set so that a set in the same cycle wins
    if (rd_csr || wr_cvr) begin
      next_zero_reached_flag = 1'b0; // [RULE3]
    end
    if (hit_zero && !wr_cvr) begin
      next_zero_reached_flag = 1'b1; // [RULE2]
      next_pend = exc_enable; // [RULE6] [RULE7]
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_enable <= CSR_RESET[STK_BIT_ENABLE]; // [RULE13]
      exc_enable <= CSR_RESET[STK_BIT_EXC_ENABLE];
      clock_select <= CSR_RESET[STK_BIT_CLOCK_SELECT];
      zero_reached_flag <= CSR_RESET[STK_BIT_ZERO_FLAG];
      reload_value <= STK_RELOAD_RESET;
      current_value <= STK_CURRENT_RESET;
      rdata_q <= STK_READ_ZERO;
      ack_q <= 1'b0;
      pend_q <= 1'b0;
    end else if (clk_en) begin
      count_enable <= next_count_enable;
      exc_enable <= next_exc_enable;
      clock_select <= next_clock_select;
      zero_reached_flag <= next_zero_reached_flag;
      reload_value <= next_reload_value;
      current_value <= next_current_value;
      rdata_q <= next_rdata;
      ack_q <= next_ack;
      pend_q <= next_pend;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_ack = ack_q;
  assign tick_pend = pend_q;

endmodule // stk_timer

// *** tb/stk_timer_props.sv ***
// checker for the tick timer port behaviour
// assumes binding to stk_timer with clk_en held high
`timescale 1ns/1ps
module stk_timer_props
  import stk_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // register port
  input wire logic reg_sel,
  input wire logic reg_write,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_ack,
  // status and tick
  input wire logic debug_halted,
  input wire logic ref_clk_in,
  input wire logic tick_pend
);
  logic req;
  logic rd;
  logic [1:0] ctl;
  assign req = reg_sel & clk_en;
  assign rd = req & ~reg_write;
  // mirror of the enable bits
  always_ff @(posedge sys_clk) begin
    if (rst)
      ctl <= 2'h0;
    else if (req && reg_write && reg_addr == STK_ADDR_CONTROL_STATUS)
      ctl <= reg_wdata[1:0];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_ack_after_req: assert property (req |=> reg_ack)
    else $error("ack missing after request");
  chk_ack_has_cause: assert property (reg_ack |-> $past(req))
    else $error("ack without request");
  chk_upper_zero: assert property (rd && (reg_addr == STK_ADDR_RELOAD_VALUE ||
    reg_addr == STK_ADDR_CURRENT_VALUE) |=> reg_rdata[31:24] == 8'h00)
    else $error("upper count bits not zero");
  chk_reserved_zero: assert property (rd && reg_addr inside
    {[32'he000e020:32'he000e0ff]} |=> reg_rdata == 32'h00000000)
    else $error("reserved word not zero");
  chk_clear_no_pend: assert property (req && reg_write &&
    reg_addr == STK_ADDR_CURRENT_VALUE |=> !tick_pend [*2])
    else $error("pend after current value write");
  chk_pend_enabled: assert property (tick_pend |-> $past(ctl) == 2'h3)
    else $error("pend while not enabled");
  chk_halt_no_pend: assert property (tick_pend |-> !$past(debug_halted))
    else $error("pend while halted");
  chk_pend_single: assert property (tick_pend |=> !tick_pend)
    else $error("pend longer than one cycle");
  cover property (tick_pend);
  cover property (rd && reg_addr == STK_ADDR_CONTROL_STATUS ##1 reg_rdata[16]);
  cover property (req && reg_write && reg_addr == STK_ADDR_CURRENT_VALUE);
endmodule // stk_timer_props

bind stk_timer stk_timer_props u_props (
  .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_sel(reg_sel),
  .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_ack(reg_ack), .debug_halted(debug_halted),
  .ref_clk_in(ref_clk_in), .tick_pend(tick_pend));

// *** tb/stk_timer_tb.sv ***
// self-checking bench for the system tick timer
// assumes DUT uses the defaults; two more instances cover no reference clock and timer absent
`timescale 1ns/1ps
module stk_timer_tb;
  import stk_pkg::*;
  localparam logic [31:0] CSR = STK_ADDR_CONTROL_STATUS;
  localparam logic [31:0] RVR = STK_ADDR_RELOAD_VALUE;
  localparam logic [31:0] CVR = STK_ADDR_CURRENT_VALUE;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_sel = 1'b0;
  logic reg_write = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic reg_ack;
  logic debug_halted = 1'b0;
  logic ref_clk_in = 1'b0;
  logic tick_pend;
  logic [31:0] rdata_nr;
  logic ack_nr;
  logic pend_nr;
  logic [31:0] rdata_ab;
  logic ack_ab;
  logic pend_ab;
  logic [31:0] d_nr;
  logic [31:0] d_ab;
  logic [31:0] d;
  logic [31:0] d2;
  int error_cnt = 0;
  int n_checks = 0;
  int pend_cnt = 0;
  int cyc = 0;
  int last_cyc = 0;
  int gap = 0;
  int p;
  always #20 sys_clk = ~sys_clk;
  stk_timer DUT (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .reg_sel(reg_sel),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .debug_halted(debug_halted),
    .ref_clk_in(ref_clk_in), .tick_pend(tick_pend));
  // same bus, no reference clock: clock select fixed to the processor clock
  stk_timer #(.HAS_REF_CLOCK(1'b0)) DUT_noref (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
    .reg_sel(reg_sel), .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(rdata_nr), .reg_ack(ack_nr), .debug_halted(debug_halted),
    .ref_clk_in(ref_clk_in), .tick_pend(pend_nr));
  // same bus, timer configured out: whole range reserved
  stk_timer #(.TIMER_PRESENT(1'b0)) DUT_absent (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
    .reg_sel(reg_sel), .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(rdata_ab), .reg_ack(ack_ab), .debug_halted(debug_halted),
    .ref_clk_in(ref_clk_in), .tick_pend(pend_ab));
  // counts pend pulses and the spacing between them
  always @(posedge sys_clk) begin
    cyc++;
    if (tick_pend === 1'b1) begin
      pend_cnt++;
      gap = cyc - last_cyc;
      last_cyc = cyc;
    end
  end
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task acc(logic w, logic [31:0] a, logic [31:0] wd);
    @(posedge sys_clk);
    #1;
    reg_sel = 1'b1;
    reg_write = w;
    reg_addr = a;
    reg_wdata = wd;
    @(posedge sys_clk);
    #1;
    reg_sel = 1'b0;
    d = reg_rdata;
    d_nr = rdata_nr;
    d_ab = rdata_ab;
    chk("ack", {29'h0, reg_ack, ack_nr, ack_ab}, 32'h7);
  endtask
  task wr(logic [31:0] a, logic [31:0] wd);
    acc(1'b1, a, wd);
  endtask
  task rc(string nm, logic [31:0] a, logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(nm, d, exp);
  endtask
  task wait_pend(int n);
    int s;
    s = pend_cnt;
    for (int i = 0; i < n && pend_cnt == s; i++) @(posedge sys_clk);
    chk("pend", pend_cnt - s, 1);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #120000;
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    rc("csr_reset", CSR, STK_CSR_RESET_WITH_REF);
    chk("csr_reset_noref", d_nr, STK_CSR_RESET_NO_REF);
    chk("csr_reset_absent", d_ab, 32'h0);
    wr(32'he000e020, 32'hffffffff);
    rc("reserved", 32'he000e020, 32'h0);
    wr(RVR, 32'hffffffff);
    rc("reload_wide", RVR, 32'h00ffffff);
    chk("absent_rvr", d_ab, 32'h0);
    wr(CSR, 32'h0);
    rc("csr_zero", CSR, 32'h0);
    chk("noref_clksel", d_nr, STK_CSR_RESET_NO_REF);
    $display("test map done");
    wr(RVR, 32'h10);
    wr(CVR, 32'h5a);
    wr(CSR, 32'h7);
    rc("count_a", CVR, 32'h10);
    rc("count_b", CVR, 32'he);
    wait_pend(40);
    wait_pend(40);
    chk("period", gap, 17);
    rc("flag_set", CSR, 32'h10007);
    rc("flag_read", CSR, 32'h7);
    wait_pend(40);
    p = pend_cnt;
    wr(CVR, 32'hffffffff);
    rc("cvr_clear", CVR, 32'h10);
    rc("flag_cvr", CSR, 32'h7);
    chk("cvr_no_pend", pend_cnt, p);
    $display("test count done");
    wr(CSR, 32'h5);
    p = pend_cnt;
    repeat (40) @(posedge sys_clk);
    chk("no_exc", pend_cnt, p);
    rc("flag_noexc", CSR, 32'h10005);
    debug_halted = 1'b1;
    acc(1'b0, CVR, 32'h0);
    d2 = d;
    rc("halt", CVR, d2);
    debug_halted = 1'b0;
    wr(CSR, 32'h4);
    acc(1'b0, CVR, 32'h0);
    d2 = d;
    rc("disabled", CVR, d2);
    $display("test hold done");
    wr(RVR, 32'h0);
    wr(CSR, 32'h7);
    repeat (40) @(posedge sys_clk);
    p = pend_cnt;
    repeat (40) @(posedge sys_clk);
    chk("park_pend", pend_cnt, p);
    rc("park", CVR, 32'h0);
    $display("test reload_zero done");
    wr(RVR, 32'h3);
    wr(CVR, 32'h0);
    wr(CSR, 32'h3);
    rc("clksel", CSR, 32'h3);
    p = pend_cnt;
    repeat (16) begin
      ref_clk_in = 1'b1;
      repeat (4) @(posedge sys_clk);
      #1;
      ref_clk_in = 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
    end
    repeat (8) @(posedge sys_clk);
    chk("ref_ticks", pend_cnt - p, 4);
    $display("test ref_clock done");
    complete_run();
  end
endmodule // stk_timer_tb
